// [design/cpureg_core_regs.sv]
// Notes on behaviour
// - Registers are off the memory map entirely.
// - Eight-bit accumulator holds operands and results.
// - Two index registers; prefix selects the second.
// - Interrupt save/restore never touches second index.
// - Sixteen-bit pointer, low and high byte halves.
// - Flag layout fixed; resets to 111x1xxx.
// - Flags push/pop and per-bit set/clear supported.
// - Half carry from bit 3 on add.
// - Half carry drives two conditional jumps.
// - Negative flag copies result bit 7.
// - Zero flag set when result is zero.
// - Carry records overflow; hardware or software writes.
// - Force set/clear, shifts, bit-test update carry.
// - Jump pairs test negative, zero and carry.
// - Priority pair encodes levels 0 to 3.
// - Interrupt entry loads pair from priority registers.
`timescale 1ns/100ps
`default_nettype none

// Architectural register set, driven only by the core's decode logic.
// There is no address port at all: nothing here is memory mapped.
module cpureg_core_regs (
    // Clock and reset.
    input  wire logic                   clk_i,
    input  wire logic                   rst_n_i,
    // Register write port from decode.
    input  wire logic                   wr_en_i,
    input  wire logic [2:0]             wr_sel_i,
    input  wire logic                   pre_second_i,
    input  wire logic [7:0]             wr_data_i,
    // Pointer sequencing.
    input  wire logic                   ptr_load_i,
    input  wire logic [15:0]            ptr_data_i,
    input  wire logic                   ptr_inc_i,
    // ALU result and flag update class.
    input  wire cpureg_pkg::cpureg_fop_type fop_i,
    input  wire logic [7:0]             alu_result_i,
    input  wire logic                   alu_half_i,
    input  wire logic                   alu_carry_i,
    input  wire logic                   alu_to_acc_i,
    // Per-bit flag control and whole-register restore.
    input  wire logic                   flag_bit_en_i,
    input  wire logic [2:0]             flag_bit_sel_i,
    input  wire logic                   flag_bit_val_i,
    input  wire logic                   carry_set_i,
    input  wire logic                   carry_clr_i,
    input  wire logic                   flags_pop_i,
    input  wire logic [7:0]             flags_pop_data_i,
    // Interrupt priority handling.
    input  wire logic                   irq_entry_i,
    input  wire logic [1:0]             irq_prio_i,
    input  wire logic                   ctx_restore_i,
    input  wire logic [7:0]             ctx_acc_i,
    input  wire logic [7:0]             ctx_idx_i,
    // Branch condition.
    input  wire logic [3:0]             br_cond_i,
    // Register outputs.
    output logic [7:0]                  acc_o,
    output logic [7:0]                  first_idx_o,
    output logic [7:0]                  second_idx_o,
    output logic [15:0]                 ptr_o,
    output logic [7:0]                  flags_o,
    output logic                        br_take_o,
    output logic                        irq_disabled_o
);
    import cpureg_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // State.

    logic [7:0]  acc_r,   acc_nxt;     // Accumulator.
    logic [7:0]  idx1_r,  idx1_nxt;    // First index.
    logic [7:0]  idx2_r,  idx2_nxt;    // Second index.
    logic [15:0] ptr_r,   ptr_nxt;     // Next instruction pointer.
    logic [7:0]  flags_r, flags_nxt;   // Condition flags.
    logic        take_r,  take_nxt;    // Registered branch decision.
    logic        irq_dis_r, irq_dis_nxt; // Registered level-3 (interrupts off) indication.
    logic        ev_neg;               // Computed negative.
    logic        ev_zero;              // Computed zero.
    logic        ev_half;              // Computed half carry.
    logic        take_c;               // Combinational branch decision.

    ////////////////////////////////////////////////////////////////////////
    // Helpers.

    cpureg_flag_eval u_eval (
        .result_i (alu_result_i),
        .half_i   (alu_half_i),
        .neg_o    (ev_neg),
        .zero_o   (ev_zero),
        .half_o   (ev_half)
    );

    // The decision is taken on the next-cycle flags so it matches what is stored.
    cpureg_branch_test u_branch (
        .cond_i  (br_cond_i),
        .flags_i (flags_nxt),
        .take_o  (take_c)
    );

    ////////////////////////////////////////////////////////////////////////
    // Data registers and pointer.

    // Decode writes steer one register; the prefix redirects first to second index.
    always_comb begin
        acc_nxt  = acc_r;
        idx1_nxt = idx1_r;
        idx2_nxt = idx2_r;
        ptr_nxt  = ptr_r;
        if (alu_to_acc_i) begin
            acc_nxt = alu_result_i;
        end
        if (wr_en_i) begin
            case (wr_sel_i)
                SEL_ACC:  acc_nxt = wr_data_i;
                SEL_IDX1: begin
                    if (pre_second_i) begin
                        idx2_nxt = wr_data_i;
                    end else begin
                        idx1_nxt = wr_data_i;
                    end
                end
                SEL_IDX2:  idx2_nxt = wr_data_i;
                SEL_PLOW:  ptr_nxt[7:0] = wr_data_i;
                SEL_PHIGH: ptr_nxt[15:8] = wr_data_i;
                default: begin
                end
            endcase
        end
        // Context restore reloads accumulator and first index only.
        if (ctx_restore_i) begin
            acc_nxt  = ctx_acc_i;
            idx1_nxt = ctx_idx_i;
        end
        if (ptr_load_i) begin
            ptr_nxt = ptr_data_i;
        end else if (ptr_inc_i) begin
            ptr_nxt = ptr_r + 16'h0001;
        end
    end

    // Registers only.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            acc_r  <= ACC_RESET;
            idx1_r <= IDX_RESET;
            idx2_r <= IDX_RESET;
            ptr_r  <= PTR_RESET;
        end else begin
            acc_r  <= acc_nxt;
            idx1_r <= idx1_nxt;
            idx2_r <= idx2_nxt;
            ptr_r  <= ptr_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Condition flags.

    // Lower priority updates first, later statements override. Flags not
    // named by an operation class keep their value.
    always_comb begin
        flags_nxt = flags_r;
        case (fop_i)
            FOP_ADD: begin
                flags_nxt[HF_BIT] = ev_half;
                flags_nxt[NF_BIT] = ev_neg;
                flags_nxt[ZF_BIT] = ev_zero;
                flags_nxt[CF_BIT] = alu_carry_i;
            end
            FOP_ARITH: begin
                flags_nxt[NF_BIT] = ev_neg;
                flags_nxt[ZF_BIT] = ev_zero;
                flags_nxt[CF_BIT] = alu_carry_i;
            end
            FOP_SHIFT: begin
                flags_nxt[NF_BIT] = ev_neg;
                flags_nxt[ZF_BIT] = ev_zero;
                flags_nxt[CF_BIT] = alu_carry_i;
            end
            FOP_LOGIC: begin
                flags_nxt[NF_BIT] = ev_neg;
                flags_nxt[ZF_BIT] = ev_zero;
            end
            FOP_BTJ: begin
                flags_nxt[CF_BIT] = alu_carry_i;
            end
            default: begin
            end
        endcase
        if (flag_bit_en_i) begin
            flags_nxt[flag_bit_sel_i] = flag_bit_val_i;
        end
        if (carry_set_i) begin
            flags_nxt[CF_BIT] = 1'b1;
        end else if (carry_clr_i) begin
            flags_nxt[CF_BIT] = 1'b0;
        end
        if (flags_pop_i) begin
            flags_nxt = flags_pop_data_i;
        end
        // Interrupt entry loads the priority pair last so it always wins.
        if (irq_entry_i) begin
            flags_nxt[PHI_BIT] = irq_prio_i[1];
            flags_nxt[PLO_BIT] = irq_prio_i[0];
        end
        // Top two bits are hard ones; a pop cannot clear them.
        flags_nxt[ONE7_BIT] = 1'b1;
        flags_nxt[ONE6_BIT] = 1'b1;
        take_nxt = take_c;
        // Decoded from the next flags so the output can come from its own flop.
        irq_dis_nxt = ({flags_nxt[PHI_BIT], flags_nxt[PLO_BIT]} == PRIO_LVL3);
    end

    // Registers only.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            flags_r   <= CF_RESET;
            take_r    <= 1'b0;
            irq_dis_r <= CF_RESET[PHI_BIT] & CF_RESET[PLO_BIT];
        end else begin
            flags_r   <= flags_nxt;
            take_r    <= take_nxt;
            irq_dis_r <= irq_dis_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from flip-flops.

    assign acc_o          = acc_r;
    assign first_idx_o    = idx1_r;
    assign second_idx_o   = idx2_r;
    assign ptr_o          = ptr_r;
    assign flags_o        = flags_r;
    assign br_take_o      = take_r;
    // Level 3 is both pair bits set; kept in its own flop.
    assign irq_disabled_o = irq_dis_r;

    ////////////////////////////////////////////////////////////////////////
    // Assertions.

    fixed_ones_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        flags_o[7:6] == 2'h3)
        else $error("Fixed flag bits not one.");

    second_kept_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ctx_restore_i && !wr_en_i) |=> second_idx_o == $past(second_idx_o))
        else $error("Second index changed on restore.");

    half_add_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (fop_i == FOP_ADD && !flag_bit_en_i && !flags_pop_i)
        |=> flags_o[HF_BIT] == $past(alu_half_i))
        else $error("Half carry not loaded on add.");

    neg_copy_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (fop_i inside {FOP_ADD, FOP_ARITH, FOP_LOGIC, FOP_SHIFT}
         && !flag_bit_en_i && !flags_pop_i)
        |=> flags_o[NF_BIT] == $past(alu_result_i[7]))
        else $error("Negative flag mismatch.");

    zero_det_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (fop_i == FOP_LOGIC && !flag_bit_en_i && !flags_pop_i)
        |=> flags_o[ZF_BIT] == ($past(alu_result_i) == 8'h00))
        else $error("Zero flag mismatch.");

    carry_force_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (carry_set_i && !flags_pop_i) |=> flags_o[CF_BIT])
        else $error("Carry not forced set.");

    flags_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (fop_i == FOP_NONE && !flag_bit_en_i && !carry_set_i && !carry_clr_i
         && !flags_pop_i && !irq_entry_i) |=> $stable(flags_o))
        else $error("Flags changed without cause.");

    prio_load_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        irq_entry_i |=> {flags_o[PHI_BIT], flags_o[PLO_BIT]} == $past(irq_prio_i))
        else $error("Priority pair not loaded.");

    branch_carry_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ##1 ($past(br_cond_i) == BR_CARRY) |-> br_take_o == flags_o[CF_BIT])
        else $error("Carry branch decision wrong.");

    ptr_inc_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ptr_inc_i && !ptr_load_i && !wr_en_i) |=> ptr_o == $past(ptr_o) + 16'h0001)
        else $error("Pointer did not advance.");

endmodule
`default_nettype wire

// [design/cpureg_pkg.sv]
package cpureg_pkg;

    // Data and pointer widths of the architectural registers.
    localparam int DATA_W = 8;
    localparam int PTR_W  = 16;

    // Bit positions inside the condition flags register.
    localparam int CF_BIT   = 0;
    localparam int ZF_BIT   = 1;
    localparam int NF_BIT   = 2;
    localparam int PLO_BIT  = 3;
    localparam int HF_BIT   = 4;
    localparam int PHI_BIT  = 5;
    localparam int ONE6_BIT = 6;
    localparam int ONE7_BIT = 7;

    // Reset value: ones in 7,6,5,3; undefined bits chosen as zero.
    localparam logic [7:0] CF_RESET = 8'he8;

    // Interrupt priority pair encodings {high,low}.
    localparam logic [1:0] PRIO_LVL0 = 2'h2;
    localparam logic [1:0] PRIO_LVL1 = 2'h1;
    localparam logic [1:0] PRIO_LVL2 = 2'h0;
    localparam logic [1:0] PRIO_LVL3 = 2'h3;

    // Reset values of data registers and pointer.
    localparam logic [7:0]  ACC_RESET = 8'h00;
    localparam logic [7:0]  IDX_RESET = 8'h00;
    localparam logic [15:0] PTR_RESET = 16'h0000;

    // Register selectors for the internal write port.
    localparam logic [2:0] SEL_ACC   = 3'h0;
    localparam logic [2:0] SEL_IDX1  = 3'h1;
    localparam logic [2:0] SEL_IDX2  = 3'h2;
    localparam logic [2:0] SEL_PLOW  = 3'h3;
    localparam logic [2:0] SEL_PHIGH = 3'h4;
    localparam logic [2:0] SEL_FLAGS = 3'h5;

    // Branch condition codes.
    localparam logic [3:0] BR_HALF   = 4'h0;
    localparam logic [3:0] BR_NOHALF = 4'h1;
    localparam logic [3:0] BR_MINUS  = 4'h2;
    localparam logic [3:0] BR_PLUS   = 4'h3;
    localparam logic [3:0] BR_EQUAL  = 4'h4;
    localparam logic [3:0] BR_NEQUAL = 4'h5;
    localparam logic [3:0] BR_CARRY  = 4'h6;
    localparam logic [3:0] BR_NCARRY = 4'h7;

    // Flag operation classes driven by decode.
    typedef enum logic [5:0] {
        FOP_NONE  = 6'b000001,
        FOP_ADD   = 6'b000010,
        FOP_LOGIC = 6'b000100,
        FOP_ARITH = 6'b001000,
        FOP_SHIFT = 6'b010000,
        FOP_BTJ   = 6'b100000
    } cpureg_fop_type;

endpackage

// [design/cpureg_flag_eval.sv]
`timescale 1ns/100ps
`default_nettype none

// Computes flag values from an ALU result; purely combinational.
module cpureg_flag_eval (
    // ALU result inputs.
    input  wire logic [7:0] result_i,
    input  wire logic       half_i,
    // Computed flags.
    output logic            neg_o,
    output logic            zero_o,
    output logic            half_o
);
    import cpureg_pkg::*;

    // Sign copy, zero detect and half carry pass-through.
    always_comb begin
        neg_o  = result_i[DATA_W-1];
        zero_o = (result_i == 8'h00);
        half_o = half_i;
    end

endmodule
`default_nettype wire

// [design/cpureg_branch_test.sv]
`timescale 1ns/100ps
`default_nettype none

// Evaluates a branch condition against the flags it is given (the next-cycle flags in the core).
module cpureg_branch_test (
    // Condition select and flags.
    input  wire logic [3:0] cond_i,
    input  wire logic [7:0] flags_i,
    // Branch decision.
    output logic            take_o
);
    import cpureg_pkg::*;

    // One pair of conditions per tested flag.
    always_comb begin
        case (cond_i)
            BR_HALF:   take_o = flags_i[HF_BIT];
            BR_NOHALF: take_o = !flags_i[HF_BIT];
            BR_MINUS:  take_o = flags_i[NF_BIT];
            BR_PLUS:   take_o = !flags_i[NF_BIT];
            BR_EQUAL:  take_o = flags_i[ZF_BIT];
            BR_NEQUAL: take_o = !flags_i[ZF_BIT];
            BR_CARRY:  take_o = flags_i[CF_BIT];
            BR_NCARRY: take_o = !flags_i[CF_BIT];
            default:   take_o = 1'b0;
        endcase
    end

endmodule
`default_nettype wire

// [verif/testbench.sv]
`timescale 1ns/100ps
`default_nettype none

module testbench;
    import cpureg_pkg::*;

    // Clock, reset and decode-side stimulus.
    logic                clk_i;
    logic                rst_n_i;
    logic                wr_en_i;
    logic [2:0]          wr_sel_i;
    logic                pre_second_i;
    logic [7:0]          wr_data_i;
    logic                ptr_load_i;
    logic [15:0]         ptr_data_i;
    logic                ptr_inc_i;
    cpureg_fop_type      fop_i;
    logic [7:0]          alu_result_i;
    logic                alu_half_i;
    logic                alu_carry_i;
    logic                alu_to_acc_i;
    logic                flag_bit_en_i;
    logic [2:0]          flag_bit_sel_i;
    logic                flag_bit_val_i;
    logic                carry_set_i;
    logic                carry_clr_i;
    logic                flags_pop_i;
    logic [7:0]          flags_pop_data_i;
    logic                irq_entry_i;
    logic [1:0]          irq_prio_i;
    logic                ctx_restore_i;
    logic [7:0]          ctx_acc_i;
    logic [7:0]          ctx_idx_i;
    logic [3:0]          br_cond_i;
    // Observed register outputs.
    logic [7:0]          acc_o;
    logic [7:0]          first_idx_o;
    logic [7:0]          second_idx_o;
    logic [15:0]         ptr_o;
    logic [7:0]          flags_o;
    logic                br_take_o;
    logic                irq_disabled_o;
    // Result counters.
    int                  err_total;
    int                  n_checks;

    cpureg_core_regs i_cpureg_core_regs (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .wr_en_i(wr_en_i), .wr_sel_i(wr_sel_i),
        .pre_second_i(pre_second_i), .wr_data_i(wr_data_i), .ptr_load_i(ptr_load_i),
        .ptr_data_i(ptr_data_i), .ptr_inc_i(ptr_inc_i), .fop_i(fop_i),
        .alu_result_i(alu_result_i), .alu_half_i(alu_half_i), .alu_carry_i(alu_carry_i),
        .alu_to_acc_i(alu_to_acc_i), .flag_bit_en_i(flag_bit_en_i),
        .flag_bit_sel_i(flag_bit_sel_i), .flag_bit_val_i(flag_bit_val_i),
        .carry_set_i(carry_set_i), .carry_clr_i(carry_clr_i), .flags_pop_i(flags_pop_i),
        .flags_pop_data_i(flags_pop_data_i), .irq_entry_i(irq_entry_i),
        .irq_prio_i(irq_prio_i), .ctx_restore_i(ctx_restore_i), .ctx_acc_i(ctx_acc_i),
        .ctx_idx_i(ctx_idx_i), .br_cond_i(br_cond_i), .acc_o(acc_o),
        .first_idx_o(first_idx_o), .second_idx_o(second_idx_o), .ptr_o(ptr_o),
        .flags_o(flags_o), .br_take_o(br_take_o), .irq_disabled_o(irq_disabled_o)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Clock at 200 MHz.
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    // Prints the verdict and ends the run.
    task automatic summarize();
        if (err_total == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Compares one observed value with its expectation; X and Z bits must match exactly.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Drops every request; data inputs keep their values.
    task automatic idle();
        wr_en_i = 1'b0;
        pre_second_i = 1'b0;
        ptr_load_i = 1'b0;
        ptr_inc_i = 1'b0;
        fop_i = FOP_NONE;
        alu_to_acc_i = 1'b0;
        flag_bit_en_i = 1'b0;
        carry_set_i = 1'b0;
        carry_clr_i = 1'b0;
        flags_pop_i = 1'b0;
        irq_entry_i = 1'b0;
        ctx_restore_i = 1'b0;
    endtask

    // Lets one rising edge take the request, releases it, then lets an idle edge
    // pass so that a following request never reassigns a strobe in one time step.
    task automatic tick();
        @(negedge clk_i);
        idle();
        @(negedge clk_i);
    endtask

    // One write through the decode port.
    task automatic wr(input logic [2:0] sel, input logic [7:0] d, input logic pre);
        wr_en_i = 1'b1;
        wr_sel_i = sel;
        wr_data_i = d;
        pre_second_i = pre;
        tick();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Register writes, prefix redirection, pointer halves, wrap and load priority.
    task automatic t_regs();
        wr(SEL_ACC, 8'h5a, 1'b0);
        check(16'(acc_o), 16'h005a);
        wr(SEL_IDX1, 8'h3c, 1'b0);
        wr(SEL_IDX1, 8'hc3, 1'b1);
        check({first_idx_o, second_idx_o}, 16'h3cc3);
        wr(SEL_IDX2, 8'h96, 1'b0);
        check(16'(second_idx_o), 16'h0096);
        wr(SEL_PLOW, 8'hfe, 1'b0);
        wr(SEL_PHIGH, 8'hff, 1'b0);
        check(ptr_o, 16'hfffe);
        ptr_inc_i = 1'b1;
        @(negedge clk_i);
        check(ptr_o, 16'hffff);
        tick();
        check(ptr_o, 16'h0000);
        // Selector 5 has no target, so the flags must not move.
        wr(SEL_FLAGS, 8'h00, 1'b0);
        check(16'(flags_o), 16'h00e8);
        ptr_load_i = 1'b1;
        ptr_data_i = 16'h1234;
        ptr_inc_i = 1'b1;
        wr(SEL_PLOW, 8'h77, 1'b0);
        check(ptr_o, 16'h1234);
    endtask

    // Context restore reloads accumulator and first index only.
    task automatic t_ctx();
        ctx_restore_i = 1'b1;
        ctx_acc_i = 8'h11;
        ctx_idx_i = 8'h22;
        tick();
        check({acc_o, first_idx_o}, 16'h1122);
        check(16'(second_idx_o), 16'h0096);
    endtask

    // One ALU result with a flag class; the sign branch is watched alongside.
    task automatic alu(input cpureg_fop_type f, input logic [7:0] r, input logic h,
                       input logic c, input logic [7:0] exp);
        fop_i = f;
        alu_result_i = r;
        alu_half_i = h;
        alu_carry_i = c;
        alu_to_acc_i = 1'b1;
        br_cond_i = BR_MINUS;
        tick();
        check({acc_o, flags_o}, {r, exp});
        check(16'(br_take_o), 16'(exp[NF_BIT]));
    endtask

    // Flag classes, each touching only the flags it owns.
    task automatic t_flags();
        alu(FOP_ADD, 8'h80, 1'b1, 1'b0, 8'hfc);
        alu(FOP_ADD, 8'h00, 1'b0, 1'b1, 8'heb);
        alu(FOP_LOGIC, 8'h7f, 1'b1, 1'b0, 8'he9);
        alu(FOP_ARITH, 8'h00, 1'b1, 1'b0, 8'hea);
        alu(FOP_SHIFT, 8'h81, 1'b1, 1'b1, 8'hed);
        alu(FOP_BTJ, 8'h00, 1'b1, 1'b0, 8'hec);
        alu(FOP_NONE, 8'hff, 1'b1, 1'b1, 8'hec);
    endtask

    // Single-bit control, forced carry and whole-register pop.
    task automatic t_bits();
        flag_bit_en_i = 1'b1;
        flag_bit_sel_i = 3'h4;
        flag_bit_val_i = 1'b1;
        tick();
        check(16'(flags_o), 16'h00fc);
        // The two top bits are constant ones and refuse a clear.
        flag_bit_en_i = 1'b1;
        flag_bit_sel_i = 3'h7;
        flag_bit_val_i = 1'b0;
        tick();
        check(16'(flags_o), 16'h00fc);
        fop_i = FOP_ARITH;
        alu_result_i = 8'h01;
        alu_carry_i = 1'b0;
        carry_set_i = 1'b1;
        tick();
        check(16'(flags_o), 16'h00f9);
        carry_clr_i = 1'b1;
        tick();
        check(16'(flags_o), 16'h00f8);
        flags_pop_i = 1'b1;
        flags_pop_data_i = 8'h00;
        tick();
        check({7'h0, irq_disabled_o, flags_o}, 16'h00c0);
    endtask

    // Every priority level loaded on entry, winning over a pop in the same cycle.
    task automatic t_irq();
        logic [1:0] lvl [4];
        lvl = '{PRIO_LVL0, PRIO_LVL1, PRIO_LVL2, PRIO_LVL3};
        for (int i = 0; i < 4; i++) begin
            irq_entry_i = 1'b1;
            irq_prio_i = lvl[i];
            flags_pop_i = 1'b1;
            flags_pop_data_i = 8'hff;
            tick();
            // Bits 7,6 fixed, bit 5 high half of the pair, bit 4 popped, bit 3 low half.
            check(16'(flags_o), {8'h0, 2'b11, lvl[i][1], 1'b1, lvl[i][0], 3'b111});
            check(16'(irq_disabled_o), 16'(i == 3));
        end
    endtask

    // All branch conditions against several flag patterns.
    task automatic t_branch();
        logic [7:0] pat [4];
        logic [7:0] f;
        logic       exp;
        pat = '{8'h00, 8'h17, 8'h12, 8'h05};
        for (int p = 0; p < 4; p++) begin
            for (int c = 0; c < 9; c++) begin
                f = pat[p] | 8'hc0;
                flags_pop_i = 1'b1;
                flags_pop_data_i = pat[p];
                br_cond_i = 4'(c);
                tick();
                case (c / 2)
                    0: exp = f[HF_BIT] ^ c[0];
                    1: exp = f[NF_BIT] ^ c[0];
                    2: exp = f[ZF_BIT] ^ c[0];
                    3: exp = f[CF_BIT] ^ c[0];
                    default: exp = 1'b0;
                endcase
                check(16'(br_take_o), 16'(exp));
            end
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence: reset for 10 cycles, then every scenario in turn.
    initial begin
        err_total = 0;
        n_checks = 0;
        rst_n_i = 1'b0;
        wr_sel_i = 3'h0;
        wr_data_i = 8'h00;
        ptr_data_i = 16'h0000;
        alu_result_i = 8'h00;
        alu_half_i = 1'b0;
        alu_carry_i = 1'b0;
        flag_bit_sel_i = 3'h0;
        flag_bit_val_i = 1'b0;
        flags_pop_data_i = 8'h00;
        irq_prio_i = 2'h0;
        ctx_acc_i = 8'h00;
        ctx_idx_i = 8'h00;
        br_cond_i = 4'h0;
        idle();
        repeat (10) @(negedge clk_i);
        rst_n_i = 1'b1;
        check({acc_o, first_idx_o}, 16'h0000);
        check({second_idx_o, flags_o}, 16'h00e8);
        check({ptr_o[15:2], br_take_o, irq_disabled_o}, 16'h0001);
        t_regs();
        t_ctx();
        t_flags();
        t_bits();
        t_irq();
        t_branch();
        summarize();
    end

    // Watchdog: the scenarios need about 135 cycles, so 4000 means a hang.
    initial begin
        #(5 * 4000);
        err_total++;
        summarize();
    end

endmodule

`default_nettype wire
